//--- verilog/ifd_pkg.sv
// Operation
// - Bit words: opcode 15:12, bit number 11:9, bank bit 8, file address 7:0
// - Bank bit 0 selects access bank; bank bit 1 uses bank selector
// - Literal words: opcode 15:8, immediate 7:0 used directly as data
// - Absolute jump: target bits 7:0 first word, 19:8 second word tagged 1111
// - Bit clear 1001 bbba clears the addressed bit, no flags, one cycle
// - Extended set, bank bit 0, address at most 95: indexed literal offset mode
// - A lone second word of a two-word instruction executes as no-operation
// - Cycle is four oscillator periods; counter-changing single words take two
// - Taken relative branch adds twice offset plus two, takes two cycles
package ifd_pkg;
    // ------------------------------------------------------------
    // Opcode encodings
    // ------------------------------------------------------------
    localparam logic [3:0] OP_BIT_CLEAR   = 4'h9;
    localparam logic [3:0] OP_SECOND_WORD = 4'hf;
    localparam logic [7:0] OP_MOVE_LIT    = 8'h0e;
    localparam logic [7:0] OP_JUMP_ABS    = 8'hef;
    localparam logic [7:0] OP_BR_CARRY    = 8'he2;
    localparam logic [7:0] OP_BR_NCARRY   = 8'he3;
    localparam logic [4:0] OP_BRA_TOP     = 5'h1a;
    // ------------------------------------------------------------
    // Addressing and timing
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_LIMIT      = 8'h5f;
    localparam logic [7:0] ACCESS_SPLIT   = 8'h60;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
    localparam logic [1:0] PHASE_LAST     = 2'h3;
    localparam logic [20:0] PC_STEP       = 21'h000002;
endpackage

//--- verilog/ifd_decoder.sv
`timescale 1ns/1ps
module ifd_decoder (
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_b,
    // Program memory side
    input  wire logic [15:0] i_instr,
    input  wire logic        i_ext_set_en,
    input  wire logic [3:0]  i_bank_selector,
    input  wire logic        i_carry,
    // Program counter and data memory side
    output logic      [20:0] o_pc,
    output logic      [1:0]  o_phase,
    output logic             o_fetch,
    output logic             o_file_wr,
    output logic      [11:0] o_file_addr,
    output logic      [7:0]  o_file_bit_clr_mask,
    output logic             o_indexed_mode,
    output logic      [7:0]  o_idx_offset,
    output logic             o_work_wr,
    output logic      [7:0]  o_work_data,
    output logic             o_flags_wr
);
    typedef enum logic [2:0] {
        IFD_EXEC  = 3'b001,
        IFD_FLUSH = 3'b010,
        IFD_WORD2 = 3'b100
    } ifd_state_e;

    // ------------------------------------------------------------
    // Field extraction
    // ------------------------------------------------------------
    logic [3:0] op_hi;
    logic [7:0] op_byte;
    logic [2:0] bit_num;
    logic       bank_bit;
    logic [7:0] file_lo;
    logic       idx_hit;
    logic       is_bcf;
    logic       is_second;
    // Fields of the current word
    assign op_hi    = i_instr[15:12];
    assign bit_num  = i_instr[11:9];
    assign bank_bit = i_instr[8];
    assign file_lo  = i_instr[7:0];
    assign op_byte  = i_instr[15:8];
    assign is_bcf    = (op_hi == ifd_pkg::OP_BIT_CLEAR);
    assign is_second = (op_hi == ifd_pkg::OP_SECOND_WORD);
    assign idx_hit   = i_ext_set_en && !bank_bit && (file_lo <= ifd_pkg::IDX_LIMIT);

    // ------------------------------------------------------------
    // Instruction cycle phases
    // ------------------------------------------------------------
    logic [1:0] phase_reg;
    logic       last_q;
    // Four oscillator periods per instruction cycle
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            phase_reg <= 2'h0;
        end else begin
            phase_reg <= phase_reg + 2'h1;
        end
    end
    assign last_q  = (phase_reg == ifd_pkg::PHASE_LAST);
    assign o_phase = phase_reg;
    assign o_fetch = last_q;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    ifd_state_e state_reg;
    ifd_state_e state_next;
    logic [20:0] pc_next;
    logic [7:0]  jump_lo_reg;
    logic [20:0] br_target;
    logic        br_taken;
    // Relative branch target and condition
    always_comb begin
        br_target = o_pc + ifd_pkg::PC_STEP;
        br_taken  = 1'b0;
        if (op_byte == ifd_pkg::OP_BR_CARRY || op_byte == ifd_pkg::OP_BR_NCARRY) begin
            br_target = o_pc + ifd_pkg::PC_STEP + {{12{file_lo[7]}}, file_lo, 1'b0};
            br_taken  = (op_byte == ifd_pkg::OP_BR_CARRY) ? i_carry : !i_carry;
        end else if (i_instr[15:11] == ifd_pkg::OP_BRA_TOP) begin
            br_target = o_pc + ifd_pkg::PC_STEP + {{9{i_instr[10]}}, i_instr[10:0], 1'b0};
            br_taken  = 1'b1;
        end
    end

    // Next state and counter
    always_comb begin
        state_next = state_reg;
        pc_next    = o_pc;
        case (state_reg)
            IFD_EXEC: begin
                if (op_byte == ifd_pkg::OP_JUMP_ABS) begin
                    state_next = IFD_WORD2;
                    pc_next    = o_pc + ifd_pkg::PC_STEP;
                end else if (br_taken) begin
                    state_next = IFD_FLUSH;
                    pc_next    = br_target;
                end else begin
                    pc_next = o_pc + ifd_pkg::PC_STEP;
                end
            end
            IFD_WORD2: begin
                state_next = IFD_FLUSH;
                pc_next    = {i_instr[11:0], jump_lo_reg, 1'b0};
            end
            IFD_FLUSH: begin
                state_next = IFD_EXEC;
            end
            default: begin
                state_next = IFD_EXEC;
            end
        endcase
    end

    // State, counter and first jump literal update at cycle end
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg   <= IFD_EXEC;
            o_pc        <= 21'h0;
            jump_lo_reg <= 8'h0;
        end else if (last_q) begin
            state_reg <= state_next;
            o_pc      <= pc_next;
            if (state_reg == IFD_EXEC) begin
                jump_lo_reg <= file_lo;
            end
        end
    end

    // ------------------------------------------------------------
    // Data memory and working register results
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_file_wr           <= 1'b0;
            o_file_addr         <= 12'h0;
            o_file_bit_clr_mask <= 8'h0;
            o_indexed_mode      <= 1'b0;
            o_idx_offset        <= 8'h0;
            o_work_wr           <= 1'b0;
            o_work_data         <= 8'h0;
            o_flags_wr          <= 1'b0;
        end else begin
            o_file_wr  <= 1'b0;
            o_work_wr  <= 1'b0;
            o_flags_wr <= 1'b0;
            if (last_q && state_reg == IFD_EXEC && !is_second) begin
                if (is_bcf) begin
                    o_file_wr           <= 1'b1;
                    o_file_bit_clr_mask <= ~(8'h01 << bit_num);
                    o_indexed_mode      <= idx_hit;
                    o_idx_offset        <= file_lo;
                    if (bank_bit) begin
                        o_file_addr <= {i_bank_selector, file_lo};
                    end else if (file_lo < ifd_pkg::ACCESS_SPLIT) begin
                        o_file_addr <= {4'h0, file_lo};
                    end else begin
                        o_file_addr <= {ifd_pkg::ACCESS_HI_BANK, file_lo};
                    end
                end else if (op_byte == ifd_pkg::OP_MOVE_LIT) begin
                    o_work_wr   <= 1'b1;
                    o_work_data <= file_lo;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_BCF_ONE_PULSE: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        o_file_wr |=> !o_file_wr [*3]) else $error("file write not single");
    AST_NO_FLAGS: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        !o_flags_wr) else $error("flags written");
    AST_PHASE_WRAP: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        o_phase == ifd_pkg::PHASE_LAST |=> o_phase == 2'h0) else $error("phase wrap bad");
    AST_BANK_SEL: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (o_fetch && state_reg == IFD_EXEC && is_bcf && bank_bit)
        |=> o_file_addr[11:8] == $past(i_bank_selector)) else $error("bank wrong");
    AST_IDX_MODE: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (o_fetch && state_reg == IFD_EXEC && is_bcf)
        |=> o_indexed_mode == ($past(i_ext_set_en) && !$past(bank_bit)
                               && $past(file_lo) <= ifd_pkg::IDX_LIMIT))
        else $error("indexed mode wrong");
    AST_LIT_DATA: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        o_work_wr |-> o_work_data == $past(i_instr[7:0])) else $error("literal wrong");
    AST_NOT_TAKEN: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (o_fetch && state_reg == IFD_EXEC && !br_taken && op_byte != ifd_pkg::OP_JUMP_ABS)
        |=> o_pc == $past(o_pc) + ifd_pkg::PC_STEP ##1 state_reg == IFD_EXEC)
        else $error("untaken branch bad");
    AST_TAKEN_TWO: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (o_fetch && state_reg == IFD_EXEC && br_taken)
        |=> o_pc == $past(br_target) ##4 state_reg == IFD_EXEC)
        else $error("taken branch bad");
    AST_SECOND_NOP: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (o_fetch && state_reg == IFD_EXEC && is_second)
        |=> !o_file_wr && !o_work_wr) else $error("lone second word acted");
    AST_JUMP_TGT: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (o_fetch && state_reg == IFD_WORD2)
        |=> o_pc == {$past(i_instr[11:0]), jump_lo_reg, 1'b0}) else $error("jump bad");
    // Addressing, mask and sequencing
    AST_ACCESS_LOW: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (o_fetch && state_reg == IFD_EXEC && is_bcf && !bank_bit
         && file_lo < ifd_pkg::ACCESS_SPLIT)
        |=> o_file_addr[11:8] == 4'h0) else $error("lower access bank wrong");
    AST_ACCESS_HIGH: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (o_fetch && state_reg == IFD_EXEC && is_bcf && !bank_bit
         && file_lo >= ifd_pkg::ACCESS_SPLIT)
        |=> o_file_addr[11:8] == ifd_pkg::ACCESS_HI_BANK) else $error("upper access bank wrong");
    AST_CLR_MASK: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (o_fetch && state_reg == IFD_EXEC && is_bcf)
        |=> !o_file_bit_clr_mask[$past(bit_num)] && $countones(~o_file_bit_clr_mask) == 1)
        else $error("clear mask wrong");
    AST_IDX_OFFSET: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (o_fetch && state_reg == IFD_EXEC && is_bcf)
        |=> o_idx_offset == $past(file_lo)) else $error("indexed offset wrong");
    AST_FLUSH_QUIET: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (o_fetch && state_reg != IFD_EXEC)
        |=> !o_file_wr && !o_work_wr) else $error("write outside execute cycle");
    AST_JUMP_SEQ: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (o_fetch && state_reg == IFD_EXEC && op_byte == ifd_pkg::OP_JUMP_ABS)
        |=> state_reg == IFD_WORD2 && o_pc == $past(o_pc) + ifd_pkg::PC_STEP)
        else $error("jump first word bad");
    AST_BCF_ONE_CYCLE: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (o_fetch && state_reg == IFD_EXEC && is_bcf)
        |=> o_file_wr && state_reg == IFD_EXEC && o_pc == $past(o_pc) + ifd_pkg::PC_STEP)
        else $error("bit clear not single cycle");
endmodule

//--- dv/ifd_prog_mem.sv
`timescale 1ns/1ps
module ifd_prog_mem (
    // Clock
    input  wire logic        i_ref_clk,
    // Byte program counter from the core
    input  wire logic [20:0] i_pc,
    // Word handed to the core
    output logic      [15:0] o_instr
);
    logic [15:0] mem [0:63];
    // ------------------------------------------------------------
    // Word fetch
    // ------------------------------------------------------------
    // Unwritten places read as lone second words, never as zero
    initial begin
        for (int i = 0; i < 64; i++)
            mem[i] = 16'hffff;
    end
    // Word follows the counter, refreshed away from the sampling edge
    always @(negedge i_ref_clk) begin
        o_instr <= mem[i_pc[6:1]];
    end
endmodule

//--- dv/instruction_format_decoder_tb.sv
`timescale 1ns/1ps
module instruction_format_decoder_tb;
    logic        clk, rst_b, ext, carry, fetch, file_wr, idx, work_wr, flags_wr;
    logic [15:0] instr;
    logic [3:0]  bsel;
    logic [20:0] pc;
    logic [1:0]  phase;
    logic [11:0] faddr;
    logic [7:0]  mask, off, wdata, f1, f2, k;
    logic [2:0]  b0, b1, b2;
    logic [10:0] n;
    logic [31:0] seed;
    int          bad_count, samples_checked;
    // ------------------------------------------------------------
    // Clock, design and program memory
    // ------------------------------------------------------------
    always #2.5 clk = ~clk;
    ifd_decoder dut_u (.i_ref_clk(clk), .i_rst_b(rst_b), .i_instr(instr),
        .i_ext_set_en(ext), .i_bank_selector(bsel), .i_carry(carry), .o_pc(pc),
        .o_phase(phase), .o_fetch(fetch), .o_file_wr(file_wr), .o_file_addr(faddr),
        .o_file_bit_clr_mask(mask), .o_indexed_mode(idx), .o_idx_offset(off),
        .o_work_wr(work_wr), .o_work_data(wdata), .o_flags_wr(flags_wr));
    ifd_prog_mem mem_u (.i_ref_clk(clk), .i_pc(pc), .o_instr(instr));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    // Counter after a taken relative step of n words
    function automatic logic [20:0] rel(input logic [20:0] p, input logic [10:0] d);
        return p + 21'h000002 + {{9{d[10]}}, d, 1'b0};
    endfunction
    // Byte mask with only the chosen bit cleared
    function automatic logic [7:0] clr(input logic [2:0] b);
        return ~(8'h01 << b);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Let c instruction cycles pass, then look once outputs settle
    task automatic cyc(input int c);
        repeat (4 * c - 1) @(posedge clk);
        @(negedge clk);
        chk(phase, ifd_pkg::PHASE_LAST);
        chk(fetch, 1);
        @(posedge clk);
        @(negedge clk);
        chk(phase, 0);
        chk(fetch, 0);
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 0;
        rst_b = 0;
        carry = 0;
        ext = 1;
        bad_count = 0;
        samples_checked = 0;
        seed = xs(32'hca40d3c2);
        bsel = seed[3:0];
        b0 = seed[6:4];
        f1 = seed[15:8];
        b1 = seed[18:16];
        k = seed[27:20];
        seed = xs(seed);
        n = seed[10:0];
        f2 = {2'h0, seed[21:16]};
        b2 = seed[26:24];
        #1;
        mem_u.mem[0] = {4'h9, b0, 1'b0, 8'h60};
        mem_u.mem[1] = {4'h9, b1, 1'b1, f1};
        mem_u.mem[2] = {4'h9, 3'h7, 1'b0, 8'h5f};
        mem_u.mem[3] = {ifd_pkg::OP_MOVE_LIT, k};
        mem_u.mem[4] = {ifd_pkg::OP_BR_CARRY, 8'h03};
        mem_u.mem[5] = 16'hf123;
        mem_u.mem[6] = {ifd_pkg::OP_BR_CARRY, 8'h03};
        mem_u.mem[10] = {ifd_pkg::OP_BR_NCARRY, 8'h02};
        mem_u.mem[11] = {4'h9, b2, 1'b0, f2};
        mem_u.mem[12] = {ifd_pkg::OP_BR_NCARRY, 8'h03};
        mem_u.mem[16] = {ifd_pkg::OP_JUMP_ABS, 8'h20};
        mem_u.mem[17] = 16'hffff;
        mem_u.mem[32] = {ifd_pkg::OP_BRA_TOP, n};
        repeat (10) @(posedge clk);
        @(negedge clk);
        chk(pc, 0);
        rst_b = 1;
        cyc(1);
        chk(file_wr, 1);
        chk(flags_wr, 0);
        chk(faddr, {4'hf, 8'h60});
        chk(mask, clr(b0));
        chk(idx, 0);
        chk(pc, 21'h000002);
        cyc(1);
        chk(faddr, {bsel, f1});
        chk(mask, clr(b1));
        chk(idx, 0);
        cyc(1);
        chk(idx, 1);
        chk(off, 8'h5f);
        cyc(1);
        chk(work_wr, 1);
        chk(wdata, k);
        cyc(1);
        chk(pc, 21'h00000a);
        cyc(1);
        chk(pc, 21'h00000c);
        chk(file_wr, 0);
        chk(work_wr, 0);
        carry = 1;
        cyc(1);
        chk(pc, 21'h000014);
        cyc(1);
        chk(pc, 21'h000014);
        cyc(1);
        chk(pc, 21'h000016);
        ext = 0;
        carry = 0;
        cyc(1);
        chk(file_wr, 1);
        chk(faddr, {4'h0, f2});
        chk(mask, clr(b2));
        chk(idx, 0);
        cyc(1);
        chk(pc, 21'h000020);
        cyc(3);
        chk(pc, 21'h1ffe40);
        cyc(2);
        chk(pc, rel(21'h1ffe40, n));
        tally_and_finish();
    end
endmodule
